// ===== rtl/prlk_top.sv
/*
 * Pin routing unit with lock: input selection per peripheral, output
 * source selection per pin, two-key lock and one-way lock option,
 * reached over an Avalon-MM slave with waitrequest.
 * Assumes: por_rst and sys_rst are synchronous to clk_sys; pins and the
 * one-way option fuse are asynchronous; peripheral outputs, port
 * latches and the bus master share clk_sys.
 */
`include "prlk_params.svh"

// Notes on behaviour
// RULE_01 - Bidirectional peripherals need input and output routed to one pin.
// RULE_02 - Locked flag blocks writes to all selection registers; unlocked accepts.
// RULE_03 - Flag changes only after writes 0x55, 0xAA, then the flag write.
// RULE_04 - One-way option allows one clear and one set per reset.
// RULE_05 - One-way option: once set again, flag stays set until reset.
// RULE_06 - Sleep entry or exit leaves every selection untouched.
// RULE_07 - Power-on reset restores every selection to its default.
// RULE_08 - Other resets keep every selection value.
// RULE_09 - Input select bits 4:3 pick port A, B, C; 11 reserved.
// RULE_10 - Input select bits 2:0 pick the pin within the port.
// RULE_11 - Output select holds a 5-bit source code, zero at power-on.
// RULE_12 - Lock register has only bit 0; flag clears on every reset.
// RULE_13 - Input selects reset to peripheral-specific default codes.
// RULE_14 - Port read always returns the real pin level.
// RULE_15 - Many peripheral inputs may share one source pin.
// RULE_16 - Unsupported output source codes drive zero.
// RULE_17 - Any access breaking the key order restarts the sequence.
// RULE_18 - Reserved port code is stored but drives the input low.
module prlk_top
    import prlk_pkg::*;
(
    input wire logic clk_sys, // System clock, 250 MHz
    input wire logic sys_rst, // Any non-power-on reset
    input wire logic por_rst, // Power-on reset
    input wire prlk_av_req_t av_req, // Avalon-MM request
    output logic [31:0] avs_readdata, // Avalon-MM read data
    output logic avs_waitrequest, // Avalon-MM wait
    input wire logic one_way_lock_option, // Configuration fuse
    input wire logic [`PRLK_NUM_PIN-1:0] pin_in, // Pin levels, async
    input wire logic [`PRLK_NUM_PIN-1:0] lat_in, // Port latch bits
    input wire logic [`PRLK_NUM_SRC-1:0] periph_out, // Peripheral outputs
    output logic [`PRLK_NUM_IN-1:0] periph_in, // Routed peripheral inputs
    output logic [`PRLK_NUM_PIN-1:0] pin_out, // Routed pin outputs
    output logic [`PRLK_NUM_PIN-1:0] port_level, // Port data read levels
    output logic routing_locked_flag // Lock flag
);

    localparam prlk_state_t PRLK_STATE_RST = '{
        waitreq: 1'b1,
        readdata: 32'h0000_0000,
        stage: PRLK_UNL_IDLE,
        locked: `PRLK_LOCK_RST,
        ow_cleared: 1'b0,
        ow_final: 1'b0,
        ow_meta: 1'b0,
        ow_sync: 1'b0,
        in_sel: `PRLK_IN_RST,
        out_sel: {`PRLK_NUM_PIN{`PRLK_OUT_RST}},
        pin_meta: '0,
        pin_sync: '0,
        port_level: '0,
        periph_in: '0,
        pin_out: '0
    };

    prlk_state_t st;
    prlk_state_t next_st;
    logic [`PRLK_NUM_IN-1:0] in_route;
    logic [`PRLK_NUM_PIN-1:0] out_route;
    logic accept;
    logic hit_lock;
    logic hit_status;
    logic hit_in;
    logic hit_out;
    logic [2:0] in_idx;
    logic [4:0] out_idx;
    logic [31:0] rd_val;
    logic key_val;

    // One selector per peripheral input, all fed the same pin vector
    genvar gi;
    generate
        for (gi = 0; gi < `PRLK_NUM_IN; gi++) begin : g_in
            prlk_in_mux u_in (
                .pins (st.pin_sync), // [RULE_15]
                .sel (st.in_sel[gi]),
                .route (in_route[gi])
            );
        end
    endgenerate

    // One selector per pin
    genvar gp;
    generate
        for (gp = 0; gp < `PRLK_NUM_PIN; gp++) begin : g_out
            prlk_out_mux #(
                .SUPPORTED (`PRLK_SRC_SUPPORTED)
            ) u_out (
                .srcs (periph_out),
                .lat (lat_in[gp]),
                .code (st.out_sel[gp]),
                .drive (out_route[gp])
            );
        end
    endgenerate

    // Address decode; word aligned only, anything else is unmapped
    always_comb begin
        in_idx = av_req.address[4:2];
        out_idx = av_req.address[6:2];
        hit_lock = (av_req.address == `PRLK_LOCK_OFS);
        hit_status = (av_req.address == `PRLK_STATUS_OFS);
        hit_in = (av_req.address[7:5] == 3'(`PRLK_IN_BASE >> 5))
            && (av_req.address[1:0] == 2'h0);
        hit_out = av_req.address[7] && (av_req.address[1:0] == 2'h0)
            && (out_idx < 5'(`PRLK_NUM_PIN));
    end

    // Read mux; unimplemented upper bits and unmapped space read zero
    always_comb begin
        rd_val = 32'h0000_0000;
        if (hit_lock) begin
            rd_val[`PRLK_LOCK_BIT] = st.locked; // [RULE_12]
        end else if (hit_status) begin
            rd_val[5:0] = {st.stage, st.ow_sync, st.ow_final,
                st.ow_cleared, st.locked};
        end else if (hit_in) begin
            rd_val[`PRLK_SEL_MSB:0] = st.in_sel[in_idx]; // [RULE_09]
        end else if (hit_out) begin
            rd_val[`PRLK_SEL_MSB:0] = st.out_sel[out_idx];
        end
    end

    // Request is completed on the edge that sees waitrequest low
    assign accept = (av_req.read || av_req.write) && !st.waitreq;
    assign key_val = av_req.writedata[`PRLK_LOCK_BIT];

    // Next state: sync chains, routing, bus answer, lock and registers
    always_comb begin
        next_st = st;
        next_st.pin_meta = pin_in;
        next_st.pin_sync = st.pin_meta;
        next_st.port_level = st.pin_sync; // [RULE_14]
        next_st.ow_meta = one_way_lock_option;
        next_st.ow_sync = st.ow_meta;
        next_st.periph_in = in_route;
        next_st.pin_out = out_route;
        next_st.waitreq = 1'b1;
        // One wait cycle per request keeps read data registered
        if ((av_req.read || av_req.write) && st.waitreq) begin
            next_st.waitreq = 1'b0;
            next_st.readdata = av_req.read ? rd_val : 32'h0000_0000;
        end
        if (accept) begin
            // Any access off the key order drops back to the start
            next_st.stage = PRLK_UNL_IDLE; // [RULE_17]
            if (av_req.write && hit_lock) begin
                unique case (st.stage)
                    PRLK_UNL_IDLE: begin
                        if (av_req.writedata[7:0] == `PRLK_KEY1) begin
                            next_st.stage = PRLK_UNL_KEY1; // [RULE_03]
                        end
                    end
                    PRLK_UNL_KEY1: begin
                        if (av_req.writedata[7:0] == `PRLK_KEY2) begin
                            next_st.stage = PRLK_UNL_KEY2; // [RULE_03]
                        end else if (av_req.writedata[7:0] == `PRLK_KEY1) begin
                            next_st.stage = PRLK_UNL_KEY1;
                        end
                    end
                    PRLK_UNL_KEY2: begin
                        if (!st.ow_sync) begin
                            next_st.locked = key_val; // [RULE_03]
                        end else if (!key_val && !st.ow_cleared
                            && !st.ow_final) begin
                            next_st.locked = 1'b0; // [RULE_04]
                            next_st.ow_cleared = 1'b1;
                        end else if (key_val && !st.ow_final) begin
                            // Final set; clears refused from here on
                            next_st.locked = 1'b1; // [RULE_05]
                            next_st.ow_final = 1'b1;
                        end
                    end
                    default: begin
                        next_st.stage = PRLK_UNL_IDLE;
                    end
                endcase
            end
            // Selections change only by unlocked writes, never by sleep
            if (av_req.write && !st.locked && hit_in) begin
                next_st.in_sel[in_idx] =
                    av_req.writedata[`PRLK_SEL_MSB:0]; // [RULE_02] [RULE_06]
            end
            if (av_req.write && !st.locked && hit_out) begin
                next_st.out_sel[out_idx] =
                    av_req.writedata[`PRLK_SEL_MSB:0]; // [RULE_02] [RULE_11]
            end
        end
        // Warm reset clears the lock but keeps every selection
        if (sys_rst) begin
            next_st.locked = `PRLK_LOCK_RST; // [RULE_12]
            next_st.stage = PRLK_UNL_IDLE;
            next_st.ow_cleared = 1'b0; // [RULE_08]
            next_st.ow_final = 1'b0;
            next_st.waitreq = 1'b1;
            next_st.readdata = 32'h0000_0000;
        end
    end

    // Power-on reset alone restores selection defaults
    always_ff @(posedge clk_sys) begin
        if (por_rst) begin
            st <= PRLK_STATE_RST; // [RULE_07] [RULE_13]
        end else begin
            st <= next_st;
        end
    end

    // Outputs straight from the state flip-flops
    assign avs_readdata = st.readdata;
    assign avs_waitrequest = st.waitreq;
    assign periph_in = st.periph_in;
    assign pin_out = st.pin_out;
    assign port_level = st.port_level;
    assign routing_locked_flag = st.locked;

    // Checks on the block's own behaviour
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (por_rst || sys_rst);

    AST_LOCKED_BLOCKS_WRITE: assert property ( // [RULE_02]
        accept && av_req.write && st.locked && (hit_in || hit_out)
        |=> $stable(st.in_sel) && $stable(st.out_sel))
        else $error("selection changed while locked");

    AST_UNLOCKED_WRITE_TAKES: assert property ( // [RULE_02]
        accept && av_req.write && !st.locked && hit_in
        |=> st.in_sel[$past(in_idx)] == $past(av_req.writedata[4:0]))
        else $error("unlocked input select write lost");

    AST_FLAG_NEEDS_KEYS: assert property ( // [RULE_03]
        (st.locked != $past(st.locked)) && !$past(sys_rst)
        |-> $past(st.stage) == PRLK_UNL_KEY2 && $past(accept))
        else $error("lock flag changed without both keys");

    AST_ONE_WAY_HOLDS: assert property ( // [RULE_05]
        st.ow_final |=> st.locked [*4])
        else $error("lock flag cleared after final set");

    AST_ONE_CLEAR_ONLY: assert property ( // [RULE_04]
        st.ow_sync && $past(st.ow_cleared) && !st.locked
        && $past(st.locked) |-> 1'b0)
        else $error("second clear allowed under one-way option");

    AST_LOCK_READ_SHAPE: assert property ( // [RULE_12]
        av_req.read && st.waitreq && hit_lock
        |=> !st.waitreq && avs_readdata == {31'h0, $past(st.locked)})
        else $error("lock register read wrong");

    AST_IN_READ_UPPER_ZERO: assert property ( // [RULE_09]
        av_req.read && st.waitreq && hit_in
        |=> avs_readdata[31:5] == 27'h0)
        else $error("input select upper bits not zero");

    AST_IN_ROUTE: assert property ( // [RULE_10]
        st.in_sel[0][4:3] != 2'h3
        |=> periph_in[0] == $past(st.pin_sync[st.in_sel[0]]))
        else $error("peripheral input not routed from pin");

    AST_RSVD_PORT_LOW: assert property ( // [RULE_18]
        st.in_sel[7][4:3] == 2'h3 |=> !periph_in[7])
        else $error("reserved port did not drive low");

    AST_UNSUPPORTED_ZERO: assert property ( // [RULE_16]
        (st.out_sel[5] >= 5'h1E || st.out_sel[5] == 5'h15) |=> !pin_out[5])
        else $error("unsupported source drove a pin");

    AST_PORT_LEVEL: assert property ( // [RULE_14]
        1'b1 |=> port_level == $past(st.pin_sync))
        else $error("port level does not follow pin");

    AST_WARM_RESET_KEEPS: assert property ( // [RULE_08]
        @(posedge clk_sys) disable iff (por_rst)
        sys_rst |=> $stable(st.in_sel) && $stable(st.out_sel)
        && !st.locked)
        else $error("warm reset changed a selection");

    // Writes, key sequence, reset defaults, reads and routing of sampled pins and latches
    AST_UNLOCKED_OUT_TAKES: assert property ( // [RULE_11]
        accept && av_req.write && !st.locked && hit_out
        |=> st.out_sel[$past(out_idx)] == $past(av_req.writedata[4:0]))
        else $error("unlocked output select write lost");

    AST_SEL_ONLY_BY_WRITE: assert property ( // [RULE_06]
        !(accept && av_req.write)
        |=> $stable(st.in_sel) && $stable(st.out_sel))
        else $error("selection changed without a bus write");

    AST_POR_DEFAULTS: assert property ( // [RULE_07] [RULE_13]
        @(posedge clk_sys) disable iff (1'b0)
        por_rst |=> st.in_sel == `PRLK_IN_RST
        && st.out_sel == {`PRLK_NUM_PIN{`PRLK_OUT_RST}} && !st.locked)
        else $error("power-on reset left a selection off default");

    AST_SHARED_PIN: assert property ( // [RULE_15]
        st.in_sel[5] == st.in_sel[6] && st.in_sel[5][4:3] != 2'h3
        |=> periph_in[5] == periph_in[6])
        else $error("inputs sharing one pin disagree");

    AST_KEY_ORDER_BREAK: assert property ( // [RULE_17]
        accept && !(av_req.write && hit_lock)
        |=> st.stage == PRLK_UNL_IDLE)
        else $error("unlock sequence survived a foreign access");

    AST_SECOND_KEY: assert property ( // [RULE_03]
        accept && av_req.write && hit_lock && st.stage == PRLK_UNL_KEY1
        && av_req.writedata[7:0] == `PRLK_KEY2
        |=> st.stage == PRLK_UNL_KEY2)
        else $error("second key did not advance the sequence");

    AST_ONE_WAY_FINAL: assert property ( // [RULE_05]
        $past(st.ow_sync) && !$past(st.locked) && st.locked |-> st.ow_final)
        else $error("one-way set did not become final");

    AST_STATUS_READ: assert property ( // [RULE_04]
        av_req.read && st.waitreq && hit_status
        |=> avs_readdata[31:6] == 26'h0
        && avs_readdata[0] == $past(st.locked))
        else $error("status register read wrong");

    AST_OUT_READ_UPPER_ZERO: assert property ( // [RULE_11]
        av_req.read && st.waitreq && hit_out
        |=> avs_readdata[31:5] == 27'h0)
        else $error("output select upper bits not zero");

    AST_LATCH_PASS: assert property ( // [RULE_11]
        st.out_sel[5] == `PRLK_OUT_RST |=> pin_out[5] == $past(lat_in[5]))
        else $error("source zero did not pass the port latch");

    AST_PORT_B_ROUTE: assert property ( // [RULE_09]
        st.in_sel[2][4:3] == 2'h1
        |=> periph_in[2] == $past(st.pin_sync[{2'h1, st.in_sel[2][2:0]}]))
        else $error("port B selection not routed");

endmodule

// ===== include/prlk_params.svh
/*
 * Offsets, field positions, reset values and key codes of the pin
 * routing unit. Assumes byte addressing on a 32-bit register bus.
 */
`ifndef PRLK_PARAMS_SVH
`define PRLK_PARAMS_SVH

// Sizes of the routing fabric
`define PRLK_NUM_IN 8
`define PRLK_NUM_PIN 24
`define PRLK_NUM_SRC 32
`define PRLK_ADDR_W 8

// Register byte offsets
`define PRLK_LOCK_OFS 8'h00
`define PRLK_STATUS_OFS 8'h04
`define PRLK_IN_BASE 8'h40
`define PRLK_OUT_BASE 8'h80

// Field positions
`define PRLK_SEL_MSB 4
`define PRLK_PORT_MSB 4
`define PRLK_PORT_LSB 3
`define PRLK_LOCK_BIT 0
`define PRLK_PORT_RSVD 2'h3

// Unlock key values
`define PRLK_KEY1 8'h55
`define PRLK_KEY2 8'hAA

// Input select defaults, index 7 down to 0: data, clock of the sync
// serial port, capture1, timer3 clock, timer1 gate, timer1 clock,
// timer0 clock, pin-change interrupt
`define PRLK_IN_RST {5'h0C, 5'h0E, 5'h15, 5'h15, 5'h04, 5'h05, 5'h02, 5'h02}
`define PRLK_OUT_RST 5'h00
`define PRLK_LOCK_RST 1'b0

// Output source codes driven by this variant; 21, 30 and 31 are not
`define PRLK_SRC_SUPPORTED 32'h3FDFFFFF

`endif

// ===== include/prlk_pkg.sv
/*
 * Types of the pin routing unit: bus request carrier, unlock sequence
 * states and the whole register state of the top module.
 * Assumes prlk_params.svh is on the include path.
 */
`include "prlk_params.svh"

package prlk_pkg;

    // Avalon-MM request from the master, same clock domain
    typedef struct packed {
        logic read;
        logic write;
        logic [`PRLK_ADDR_W-1:0] address;
        logic [31:0] writedata;
    } prlk_av_req_t;

    // Progress through the two-key unlock sequence
    typedef enum logic [1:0] {
        PRLK_UNL_IDLE,
        PRLK_UNL_KEY1,
        PRLK_UNL_KEY2
    } prlk_unlock_t;

    typedef logic [`PRLK_SEL_MSB:0] prlk_sel_t;

    // All state of the top module
    typedef struct packed {
        logic waitreq;
        logic [31:0] readdata;
        prlk_unlock_t stage;
        logic locked;
        logic ow_cleared;
        logic ow_final;
        logic ow_meta;
        logic ow_sync;
        prlk_sel_t [`PRLK_NUM_IN-1:0] in_sel;
        prlk_sel_t [`PRLK_NUM_PIN-1:0] out_sel;
        logic [`PRLK_NUM_PIN-1:0] pin_meta;
        logic [`PRLK_NUM_PIN-1:0] pin_sync;
        logic [`PRLK_NUM_PIN-1:0] port_level;
        logic [`PRLK_NUM_IN-1:0] periph_in;
        logic [`PRLK_NUM_PIN-1:0] pin_out;
    } prlk_state_t;

endpackage

// ===== rtl/prlk_in_mux.sv
/*
 * One peripheral input selector: picks one synchronised pin level.
 * Assumes pins are numbered port * 8 + bit, ports A, B, C in order.
 */
`include "prlk_params.svh"
module prlk_in_mux
    import prlk_pkg::*;
(
    input wire logic [`PRLK_NUM_PIN-1:0] pins, // Synchronised pin levels
    input wire prlk_sel_t sel, // Port and bit code
    output logic route // Level for the peripheral
);

    logic [31:0] padded;

    // Padding keeps every code in range for the index
    assign padded = {{(32 - `PRLK_NUM_PIN){1'b0}}, pins};

    // Reserved port code routes nothing and holds the input low
    always_comb begin
        if (sel[`PRLK_PORT_MSB:`PRLK_PORT_LSB] == `PRLK_PORT_RSVD) begin
            route = 1'b0; // [RULE_18]
        end else begin
            route = padded[sel]; // [RULE_10]
        end
    end

endmodule

// ===== rtl/prlk_out_mux.sv
/*
 * One pin output source selector. Code zero passes the port latch.
 * Assumes peripheral outputs arrive on the same clock as this logic.
 */
`include "prlk_params.svh"
module prlk_out_mux
    import prlk_pkg::*;
#(
    parameter logic [`PRLK_NUM_SRC-1:0] SUPPORTED = `PRLK_SRC_SUPPORTED
)
(
    input wire logic [`PRLK_NUM_SRC-1:0] srcs, // Peripheral outputs
    input wire logic lat, // Port latch bit of this pin
    input wire prlk_sel_t code, // Output source code
    output logic drive // Level to drive on the pin
);

    // Codes this variant lacks drive a steady zero
    always_comb begin
        if (!SUPPORTED[code]) begin
            drive = 1'b0; // [RULE_16]
        end else if (code == `PRLK_OUT_RST) begin
            drive = lat;
        end else begin
            drive = srcs[code]; // [RULE_11]
        end
    end

endmodule

// ===== verification/prlk_far_model.sv
/*
 * Far-side model of the port pins, with optional open-drain wiring.
 * Assumes the bench changes the board levels just after clk_sys edges.
 */
`include "prlk_params.svh"
module prlk_far_model
    import prlk_pkg::*;
(
    input wire logic [`PRLK_NUM_PIN-1:0] ext_lvl, // Level from the board
    input wire logic [`PRLK_NUM_PIN-1:0] od_mask, // Open-drain bus pins
    input wire logic [`PRLK_NUM_PIN-1:0] pin_out, // Design pin drive
    output logic [`PRLK_NUM_PIN-1:0] pin_in // Level seen at the pins
);
    timeunit 1ns;
    timeprecision 100ps;
    // Bus pins read back the wired-AND, so a peripheral whose input and
    // output share one pin sees its own drive
    always_comb begin
        pin_in = ext_lvl & (pin_out | ~od_mask);
    end
endmodule

// ===== verification/prlk_top_test.sv
/*
 * Self-checking bench of the pin routing unit with lock.
 * Assumes prlk_top, prlk_far_model and the package are compiled first.
 */
`include "prlk_params.svh"
module prlk_top_test import prlk_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk_sys, sys_rst, por_rst, avs_waitrequest, fuse, locked;
    prlk_av_req_t av_req;
    logic [31:0] avs_readdata, periph_out, rd;
    logic [23:0] pin_in, lat_in, pin_out, port_level, ext_lvl, od_mask;
    logic [7:0] periph_in;
    logic [4:0] dflt [8] = '{5'h02, 5'h02, 5'h05, 5'h04, 5'h15, 5'h15,
        5'h0E, 5'h0C};
    logic [4:0] code [8] = '{5'h00, 5'h07, 5'h08, 5'h0F, 5'h10, 5'h17,
        5'h17, 5'h18};
    int n_mismatch = 0;
    int tests_run = 0;

    prlk_top u_prlk_top (.clk_sys(clk_sys), .sys_rst(sys_rst),
        .por_rst(por_rst), .av_req(av_req), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .one_way_lock_option(fuse),
        .pin_in(pin_in), .lat_in(lat_in), .periph_out(periph_out),
        .periph_in(periph_in), .pin_out(pin_out), .port_level(port_level),
        .routing_locked_flag(locked));
    prlk_far_model u_prlk_far_model (.ext_lvl(ext_lvl), .od_mask(od_mask),
        .pin_out(pin_out), .pin_in(pin_in));

    // Free-running system clock, 4 ns period
    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end

    task automatic conclude();
        if (n_mismatch == 0 && tests_run > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e,
        input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask

    // One Avalon-MM transfer; an idle edge after the release lets a
    // write settle before any check and keeps two requests apart
    task automatic acc(input logic r, input logic [7:0] a,
        input logic [31:0] d);
        int n;
        n = 0;
        av_req <= '{read: r, write: !r, address: a, writedata: d};
        do begin
            @(posedge clk_sys);
            n++;
        end while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        av_req <= '0;
        chk("wait cycles", 2, n);
        @(posedge clk_sys);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        acc(1'b0, a, d);
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] e,
        input string nm);
        acc(1'b1, a, 32'h0);
        chk(nm, e, rd);
    endtask

    function automatic logic [7:0] ia(input int i);
        return `PRLK_IN_BASE + 8'(4 * i);
    endfunction

    function automatic logic [7:0] oa(input int p);
        return `PRLK_OUT_BASE + 8'(4 * p);
    endfunction

    task automatic key(input logic v);
        wr(`PRLK_LOCK_OFS, 32'h55);
        wr(`PRLK_LOCK_OFS, 32'hAA);
        wr(`PRLK_LOCK_OFS, {31'h0, v});
    endtask

    task automatic rst(input logic por);
        @(posedge clk_sys);
        por_rst <= por;
        sys_rst <= !por;
        repeat (3) @(posedge clk_sys);
        por_rst <= 1'b0;
        sys_rst <= 1'b0;
    endtask

    task automatic t_defaults();
        for (int i = 0; i < 8; i++) rdc(ia(i), dflt[i], "in_sel rst");
        rdc(oa(0), 32'h0, "out_sel rst");
        rdc(oa(23), 32'h0, "out_sel rst");
        rdc(`PRLK_LOCK_OFS, 32'h0, "lock rst");
        rdc(8'h3C, 32'h0, "unmapped");
    endtask

    // Two inputs share pin 0x17; input 7 uses the reserved port
    task automatic t_in_route();
        logic [23:0] pat;
        for (int i = 0; i < 8; i++) wr(ia(i), 32'hFFFFFFE0 | code[i]);
        for (int k = 0; k < 2; k++) begin
            pat = k ? 24'h5AC37E : 24'hA53C81;
            ext_lvl <= pat;
            repeat (4) @(posedge clk_sys);
            chk("port_level", pat, port_level);
            for (int i = 0; i < 8; i++)
                chk("periph_in", (code[i][4:3] == 2'h3) ? 1'b0 :
                    pat[code[i]], periph_in[i]);
        end
        rdc(ia(7), 32'h18, "in_sel rsvd");
    endtask

    task automatic t_out_route();
        logic sup;
        for (int c = 0; c < 32; c++) begin
            wr(oa(5), 32'hFFFFFFE0 | c);
            sup = !(c == 21 || c == 30 || c == 31);
            for (int v = 0; v < 2; v++) begin
                lat_in <= {24{v[0]}};
                periph_out <= {32{v[0]}};
                repeat (3) @(posedge clk_sys);
                chk("pin_out", v[0] & sup, pin_out[5]);
            end
        end
        rdc(oa(5), 32'h1F, "out_sel rd");
    endtask

    // Serial data input and its bus output routed to the same pin 16
    task automatic t_bidir();
        ext_lvl <= '1;
        od_mask <= 24'h010000;
        wr(ia(7), 32'h10);
        wr(oa(16), 32'h13);
        for (int v = 0; v < 2; v++) begin
            periph_out <= {12'h0, v[0], 19'h0};
            repeat (5) @(posedge clk_sys);
            chk("bidir in", v[0], periph_in[7]);
        end
    endtask

    task automatic t_lock();
        key(1'b1);
        chk("flag", 1, locked);
        wr(ia(0), 32'h09);
        rdc(ia(0), code[0], "locked in");
        wr(oa(0), 32'h03);
        rdc(oa(0), 32'h0, "locked out");
        wr(`PRLK_LOCK_OFS, 32'h55);
        acc(1'b1, ia(0), 32'h0);
        wr(`PRLK_LOCK_OFS, 32'hAA);
        wr(`PRLK_LOCK_OFS, 32'h0);
        chk("broken seq", 1, locked);
        wr(`PRLK_LOCK_OFS, 32'h0);
        rdc(`PRLK_LOCK_OFS, 32'h1, "plain clr");
        key(1'b0);
        chk("flag clr", 0, locked);
        wr(ia(0), 32'h09);
        rdc(ia(0), 32'h09, "open in");
    endtask

    task automatic t_resets();
        fuse <= 1'b1;
        key(1'b1);
        rst(1'b0);
        chk("warm flag", 0, locked);
        rdc(ia(0), 32'h09, "warm in");
        rdc(oa(16), 32'h13, "warm out");
        key(1'b0);
        wr(ia(0), 32'h0A);
        key(1'b1);
        chk("ow set", 1, locked);
        rdc(`PRLK_STATUS_OFS, 32'h0F, "ow status");
        key(1'b0);
        chk("ow final", 1, locked);
        wr(ia(0), 32'h01);
        rdc(ia(0), 32'h0A, "ow in");
        rst(1'b1);
        rdc(ia(0), 32'h02, "por in");
        rdc(oa(16), 32'h0, "por out");
        chk("por flag", 0, locked);
    endtask

    // Run long enough for every scenario, then cut a hang short
    initial begin
        #200000;
        n_mismatch++;
        conclude();
    end

    // Main sequence after a 5-cycle reset
    initial begin
        por_rst = 1'b1;
        sys_rst = 1'b1;
        av_req = '0;
        fuse = 1'b0;
        lat_in = '0;
        periph_out = '0;
        ext_lvl = '0;
        od_mask = '0;
        repeat (5) @(posedge clk_sys);
        por_rst <= 1'b0;
        sys_rst <= 1'b0;
        t_defaults();
        t_in_route();
        t_out_route();
        t_bidir();
        t_lock();
        t_resets();
        conclude();
    end
endmodule
